// ===== inc/acs_pkg.sv
// constants, field layouts and types for the conversion sequencer
// ----------
// Operation
// RULE_01: software trigger starts one conversion, selected channel
// RULE_02: completion stores result, sets done, raises interrupt
// RULE_03: trigger bit self-clears once conversion begins
// RULE_04: software never retriggers while a conversion runs
// RULE_05: repeat code plus trigger starts repeating conversions
// RULE_06: repeat restarts immediately, updating results each time
// RULE_07: disable code aborts at once, result discarded
// RULE_08: reading the result clears the done flag
// RULE_09: new start clears done, keeps old result
// RULE_10: completion only after selected conversion time elapses
// RULE_11: software programs both controls before triggering
// RULE_12: stop mode aborts, resets controls, loses results
// RULE_13: no automatic resume after stop mode
// RULE_14: stop mode always disconnects the reference ladder
// RULE_15: result is 10-bit unsigned, split high/low
// RULE_16: software avoids port traffic during conversion
// RULE_17: time codes select 39 to 1248 clock periods
// RULE_18: busy flag set during conversion, cleared at end/stop
// RULE_19: reading high result clears done; read low first
// RULE_20: no start accepted four cycles after zero write
// RULE_21: done interrupt is one-cycle pulse with done flag
// ----------
package acs_pkg;

    // ----------
    // widths
    // ----------
    localparam int RESULT_W = 10;
    localparam int TIME_W = 11;

    // ----------
    // mode field codes
    // ----------
    localparam logic [1:0] MODE_DISABLE = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;

    // ----------
    // conversion time codes and their length in clock periods
    // ----------
    localparam logic [2:0] TCODE_39 = 3'h0;
    localparam logic [2:0] TCODE_78 = 3'h2;
    localparam logic [2:0] TCODE_156 = 3'h3;
    localparam logic [2:0] TCODE_312 = 3'h4;
    localparam logic [2:0] TCODE_624 = 3'h5;
    localparam logic [2:0] TCODE_1248 = 3'h6;
    localparam logic [TIME_W-1:0] CONV_CYC_39 = 11'h027;
    localparam logic [TIME_W-1:0] CONV_CYC_78 = 11'h04e;
    localparam logic [TIME_W-1:0] CONV_CYC_156 = 11'h09c;
    localparam logic [TIME_W-1:0] CONV_CYC_312 = 11'h138;
    localparam logic [TIME_W-1:0] CONV_CYC_624 = 11'h270;
    localparam logic [TIME_W-1:0] CONV_CYC_1248 = 11'h4e0;

    // cycles a start is held off after control one is zeroed
    localparam logic [2:0] ZERO_GUARD_CYC = 3'h4;

    // ----------
    // register layouts and reset values
    // ----------
    // control one: trigger, mode, input disable, channel
    typedef struct packed {
        logic start_trigger_bit;
        logic [1:0] conversion_mode_field;
        logic input_disable_bit;
        logic [3:0] channel_select_field;
    } acs_ctrl_one_s;

    // control two: spare, ladder, fixed one, time code, fixed zero
    typedef struct packed {
        logic [1:0] spare;
        logic ladder_connect_ctrl;
        logic fixed_one;
        logic [2:0] conv_time_field;
        logic fixed_zero;
    } acs_ctrl_two_s;

    // low result: two low result bits, done, busy, unused nibble
    typedef struct packed {
        logic [1:0] result_lsbs;
        logic conversion_done_flag;
        logic converter_busy_flag;
        logic [3:0] unused;
    } acs_result_low_s;

    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] CTRL_ZERO = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [3:0] LOW_UNUSED = 4'h0;

    // ----------
    // conversion length for a time code; reserved codes take longest
    // ----------
    // RULE_17 time code selects length
    function automatic logic [TIME_W-1:0] conv_cycles(
        input logic [2:0] code
    );
        logic [TIME_W-1:0] cyc;
        cyc = CONV_CYC_1248;
        case (code)
            TCODE_39: cyc = CONV_CYC_39;
            TCODE_78: cyc = CONV_CYC_78;
            TCODE_156: cyc = CONV_CYC_156;
            TCODE_312: cyc = CONV_CYC_312;
            TCODE_624: cyc = CONV_CYC_624;
            TCODE_1248: cyc = CONV_CYC_1248;
            default: cyc = CONV_CYC_1248;
        endcase
        return cyc;
    endfunction : conv_cycles

endpackage : acs_pkg

// ===== src/acs_conv_timer.sv
// down-counter timing one conversion
`timescale 1ns/1ns
`default_nettype none
module acs_conv_timer #(
    parameter int TIME_W = 11
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // control
    input wire logic load,
    input wire logic [TIME_W-1:0] load_cycles,
    input wire logic abort,
    // status
    output logic expired
);

    // ----------
    // counter
    // ----------
    logic [TIME_W-1:0] count_reg; // cycles left, zero when idle

    // load wins over abort so a restart in the abort cycle is kept
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_cycles;
        end else if (abort) begin
            count_reg <= '0;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - TIME_W'(1);
        end
    end

    // one-cycle pulse in the last cycle of the count
    assign expired = (count_reg == {{(TIME_W-1){1'b0}}, 1'b1}) && !abort;

endmodule : acs_conv_timer
`default_nettype wire

// ===== src/acs_sequencer.sv
// control and result logic of the 10-bit conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // control one write port
    input wire logic ctrl_one_wr,
    input wire logic [7:0] ctrl_one_wdata,
    // control two write port
    input wire logic ctrl_two_wr,
    input wire logic [7:0] ctrl_two_wdata,
    // result read strobes
    input wire logic result_high_rd,
    input wire logic result_low_rd,
    // power state
    input wire logic stop_mode,
    // analog front end
    input wire logic [acs_pkg::RESULT_W-1:0] sar_value,
    // register contents
    output acs_pkg::acs_ctrl_one_s adc_control_one,
    output acs_pkg::acs_ctrl_two_s adc_control_two,
    output logic [7:0] result_high_reg,
    output acs_pkg::acs_result_low_s result_low_reg,
    // analog control
    output logic [3:0] channel_select,
    output logic input_disable,
    output logic sample_active,
    output logic ladder_connect,
    // interrupt request
    output logic conversion_done_irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_CONVERT = 2'b01
    } acs_state_e;

    acs_state_e state_reg; // idle or converting
    acs_pkg::acs_ctrl_one_s ctrl_one_reg; // control one contents
    acs_pkg::acs_ctrl_two_s ctrl_two_reg; // control two contents
    logic [acs_pkg::RESULT_W-1:0] result_reg; // last stored result
    logic done_reg; // conversion done flag
    logic irq_reg; // interrupt pulse
    logic [2:0] guard_reg; // start hold-off after zero write
    logic [acs_pkg::RESULT_W-1:0] sar_meta_reg; // first sync stage
    logic [acs_pkg::RESULT_W-1:0] sar_sync_reg; // second sync stage

    // ---------------------------------------------------------------
    // decoded events
    // ---------------------------------------------------------------
    logic busy; // conversion in progress
    logic mode_valid; // mode field is software or repeat
    logic begin_conv; // conversion begins this cycle
    logic timer_done; // conversion time has elapsed
    logic finish; // result stored this cycle
    logic restart; // repeat mode chains another conversion
    logic abort_req; // disable code written mid conversion
    logic kill; // conversion dropped for any reason

    acs_pkg::acs_ctrl_one_s wr_one; // view of the incoming write

    assign wr_one = acs_pkg::acs_ctrl_one_s'(ctrl_one_wdata);
    assign busy = (state_reg == ACS_CONVERT);

    assign mode_valid =
        (ctrl_one_reg.conversion_mode_field == acs_pkg::MODE_SOFTWARE) ||
        (ctrl_one_reg.conversion_mode_field == acs_pkg::MODE_REPEAT);

    // RULE_01 triggered start
    // RULE_05 repeat entered the same way; RULE_20 guard blocks it
    assign begin_conv = ctrl_one_reg.start_trigger_bit && mode_valid &&
                        !busy && (guard_reg == 3'h0) && !stop_mode;

    // RULE_07 disable code stops the running conversion
    assign abort_req = busy && ctrl_one_wr && !stop_mode &&
        (wr_one.conversion_mode_field == acs_pkg::MODE_DISABLE);

    // RULE_12 stop mode also ends the conversion
    assign kill = abort_req || stop_mode;

    // RULE_10 completion only when the timer expires
    assign finish = busy && timer_done && !kill;

    // RULE_06 repeat chains the next conversion with no gap
    assign restart = finish &&
        (ctrl_one_reg.conversion_mode_field == acs_pkg::MODE_REPEAT);

    // ---------------------------------------------------------------
    // conversion timer
    // ---------------------------------------------------------------
    acs_conv_timer #(
        .TIME_W(acs_pkg::TIME_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .load(begin_conv || restart),
        .load_cycles(acs_pkg::conv_cycles(ctrl_two_reg.conv_time_field)),
        .abort(kill),
        .expired(timer_done)
    );

    // ---------------------------------------------------------------
    // analog value synchroniser
    // ---------------------------------------------------------------
    // the comparator settles outside this clock, so two stages first
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sar_meta_reg <= acs_pkg::RESULT_RESET;
            sar_sync_reg <= acs_pkg::RESULT_RESET;
        end else begin
            sar_meta_reg <= sar_value;
            sar_sync_reg <= sar_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // sequencer state
    // ---------------------------------------------------------------
    // RULE_18 busy follows the state, cleared on finish or stop
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg <= ACS_IDLE;
        end else if (kill) begin
            state_reg <= ACS_IDLE;
        end else begin
            case (state_reg)
                ACS_IDLE: begin
                    if (begin_conv) begin
                        state_reg <= ACS_CONVERT;
                    end
                end
                ACS_CONVERT: begin
                    // repeat mode stays busy across the chain
                    if (finish && !restart) begin
                        state_reg <= ACS_IDLE;
                    end
                end
                default: begin
                    state_reg <= ACS_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // control one
    // ---------------------------------------------------------------
    // RULE_12 stop mode reinitialises and locks the register
    // RULE_13 nothing is resumed: trigger is gone after stop
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_one_reg <= acs_pkg::CTRL_ONE_RESET;
        end else if (stop_mode) begin
            ctrl_one_reg <= acs_pkg::CTRL_ONE_RESET;
        end else if (ctrl_one_wr) begin
            ctrl_one_reg <= wr_one;
            // a trigger written mid conversion is ignored
            if ((busy && !abort_req) || begin_conv) begin
                ctrl_one_reg.start_trigger_bit <= 1'b0;
            end
        end else if (begin_conv) begin
            // RULE_03 trigger clears once the conversion has begun
            ctrl_one_reg.start_trigger_bit <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // start hold-off after a zero write
    // ---------------------------------------------------------------
    // RULE_20 four cycles with no start accepted
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            guard_reg <= 3'h0;
        end else if (ctrl_one_wr &&
            (ctrl_one_wdata == acs_pkg::CTRL_ZERO)) begin
            guard_reg <= acs_pkg::ZERO_GUARD_CYC;
        end else if (guard_reg != 3'h0) begin
            guard_reg <= guard_reg - 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // control two
    // ---------------------------------------------------------------
    // RULE_12 stop mode reinitialises and locks this one too
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_two_reg <= acs_pkg::CTRL_TWO_RESET;
        end else if (stop_mode) begin
            ctrl_two_reg <= acs_pkg::CTRL_TWO_RESET;
        end else if (ctrl_two_wr) begin
            ctrl_two_reg <= acs_pkg::acs_ctrl_two_s'(ctrl_two_wdata);
        end
    end

    // ---------------------------------------------------------------
    // result store
    // ---------------------------------------------------------------
    // RULE_07 an aborted value never reaches here (finish is gated)
    // RULE_09 a new start leaves the old result in place
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            result_reg <= acs_pkg::RESULT_RESET;
        end else if (stop_mode) begin
            // RULE_12 earlier results are lost
            result_reg <= acs_pkg::RESULT_RESET;
        end else if (finish) begin
            // RULE_02 result stored with the done flag
            // RULE_15 full 10-bit unsigned value
            result_reg <= sar_sync_reg;
        end
    end

    // ---------------------------------------------------------------
    // done flag
    // ---------------------------------------------------------------
    // set wins over a read in the same cycle, so no event is lost
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            done_reg <= 1'b0;
        end else if (stop_mode) begin
            done_reg <= 1'b0;
        end else if (finish) begin
            // RULE_02 done set at completion
            done_reg <= 1'b1;
        end else if (begin_conv) begin
            // RULE_09 a triggered start clears an unread done
            done_reg <= 1'b0;
        end else if (result_high_rd) begin
            // RULE_08 reading the result clears done
            // RULE_19 only the high half does so
            done_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // interrupt pulse
    // ---------------------------------------------------------------
    // RULE_21 one cycle, aligned with the done flag being set
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            // RULE_02 interrupt raised with the result
            irq_reg <= finish;
        end
    end

    // ---------------------------------------------------------------
    // register views
    // ---------------------------------------------------------------
    // low result read has no side effect; only the high half clears
    always_comb begin
        result_low_reg.result_lsbs = result_reg[1:0];
        result_low_reg.conversion_done_flag = done_reg;
        result_low_reg.converter_busy_flag = busy;
        result_low_reg.unused = acs_pkg::LOW_UNUSED;
    end

    assign result_high_reg = result_reg[acs_pkg::RESULT_W-1:2];
    assign adc_control_one = ctrl_one_reg;
    assign adc_control_two = ctrl_two_reg;
    assign conversion_done_irq = irq_reg;

    // ---------------------------------------------------------------
    // analog control
    // ---------------------------------------------------------------
    assign channel_select = ctrl_one_reg.channel_select_field;
    assign input_disable = ctrl_one_reg.input_disable_bit;
    assign sample_active = busy;

    // RULE_14 ladder forced off in stop mode
    assign ladder_connect = !stop_mode &&
        (ctrl_two_reg.ladder_connect_ctrl || busy);

endmodule : acs_sequencer
`default_nettype wire

// ===== verification/acs_analog_model.sv
// behavioural analog front end feeding the sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_analog_model (
    // channel choice
    input wire logic [3:0] channel_select,
    input wire logic input_disable,
    // converted level
    output logic [9:0] sar_value
);
    // ----------
    // level per channel
    // ----------
    // each channel shows its own level so results can be traced back;
    // a disabled input floats, shown as an odd pattern, not a hold
    assign sar_value = input_disable ? 10'h2aa : {channel_select, 6'h2d};
endmodule : acs_analog_model
`default_nettype wire

// ===== verification/acs_sequencer_properties.sv
// port assertions of the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // watched inputs
    input wire logic ctrl_one_wr,
    input wire logic [7:0] ctrl_one_wdata,
    input wire logic result_high_rd,
    input wire logic stop_mode,
    // watched outputs
    input wire acs_pkg::acs_ctrl_one_s adc_control_one,
    input wire acs_pkg::acs_ctrl_two_s adc_control_two,
    input wire logic [7:0] result_high_reg,
    input wire acs_pkg::acs_result_low_s result_low_reg,
    input wire logic sample_active,
    input wire logic ladder_connect,
    input wire logic conversion_done_irq
);
    // ----------
    // helper: cycles since start or last finish
    // ----------
    logic [10:0] run_reg; // running length of the conversion
    logic [10:0] len_t; // length the time code asks for
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !sample_active) begin
            run_reg <= 11'h000;
        end else if (conversion_done_irq) begin
            run_reg <= 11'h001;
        end else begin
            run_reg <= run_reg + 11'h001;
        end
    end
    // reserved codes run longest, as the design chose
    always_comb begin
        case (adc_control_two.conv_time_field)
            3'h0: len_t = acs_pkg::CONV_CYC_39;
            3'h2: len_t = acs_pkg::CONV_CYC_78;
            3'h3: len_t = acs_pkg::CONV_CYC_156;
            3'h4: len_t = acs_pkg::CONV_CYC_312;
            3'h5: len_t = acs_pkg::CONV_CYC_624;
            default: len_t = acs_pkg::CONV_CYC_1248;
        endcase
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    chk_irq_one_cycle: assert property (
        conversion_done_irq |=> !conversion_done_irq)
        else $error("done interrupt longer than one cycle");
    chk_irq_with_done: assert property (
        conversion_done_irq |-> result_low_reg.conversion_done_flag)
        else $error("interrupt without done flag");
    chk_start_clears_trig: assert property (
        $rose(sample_active) |-> !adc_control_one.start_trigger_bit)
        else $error("trigger still set after start");
    chk_start_cause: assert property (
        $rose(sample_active) |-> $past(adc_control_one.start_trigger_bit))
        else $error("conversion began without trigger");
    chk_conv_length: assert property (
        conversion_done_irq |-> run_reg == len_t)
        else $error("conversion length differs from time code");
    chk_abort_quiet: assert property (
        ctrl_one_wr && !stop_mode && ctrl_one_wdata[6:5] == 2'h0
        && sample_active |=> !sample_active && !conversion_done_irq)
        else $error("disable code did not stop at once");
    chk_stop_clears: assert property (
        stop_mode |=> adc_control_one == 8'h00 && adc_control_two == 8'h00
        && result_high_reg == 8'h00 && !sample_active)
        else $error("stop mode left state behind");
    chk_stop_ladder: assert property (
        stop_mode |-> !ladder_connect)
        else $error("ladder connected in stop mode");
    chk_high_read: assert property (
        result_high_rd |=> !result_low_reg.conversion_done_flag
        || conversion_done_irq)
        else $error("high read left done flag set");
    chk_result_held: assert property (
        !conversion_done_irq && !$past(stop_mode) |-> $stable(result_high_reg))
        else $error("result changed without a finish");
    chk_repeat_busy: assert property (
        conversion_done_irq && adc_control_one.conversion_mode_field
        == acs_pkg::MODE_REPEAT |-> sample_active)
        else $error("repeat mode did not chain");
    cov_repeat_finish: cover property (conversion_done_irq && sample_active);
    cov_stop_busy: cover property (stop_mode && sample_active);
    cov_abort: cover property (ctrl_one_wr && ctrl_one_wdata[6:5] == 2'h0
        && sample_active);
endmodule : acs_sequencer_properties
bind acs_sequencer acs_sequencer_properties u_acs_sequencer_properties (
    .ref_clk(ref_clk), .reset_n(reset_n), .ctrl_one_wr(ctrl_one_wr),
    .ctrl_one_wdata(ctrl_one_wdata), .result_high_rd(result_high_rd),
    .stop_mode(stop_mode), .adc_control_one(adc_control_one),
    .adc_control_two(adc_control_two), .result_high_reg(result_high_reg),
    .result_low_reg(result_low_reg), .sample_active(sample_active),
    .ladder_connect(ladder_connect),
    .conversion_done_irq(conversion_done_irq));
`default_nettype wire

// ===== verification/tb_acs_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_acs_sequencer;
    // ----------
    // signals
    // ----------
    logic ref_clk, reset_n, ctrl_one_wr, ctrl_two_wr, stop_mode;
    logic result_high_rd, result_low_rd, input_disable, sample_active;
    logic [7:0] ctrl_one_wdata, ctrl_two_wdata, result_high_reg;
    logic [9:0] sar_value;
    logic [3:0] channel_select;
    logic ladder_connect, conversion_done_irq;
    acs_pkg::acs_ctrl_one_s adc_control_one;
    acs_pkg::acs_ctrl_two_s adc_control_two;
    acs_pkg::acs_result_low_s result_low_reg;
    int n_mismatch, n_compared, n;
    // time codes, longest first so the fast one is left configured
    logic [2:0] codes [6] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
    int lens [6] = '{1248, 624, 312, 156, 78, 39};
    acs_sequencer u_acs_sequencer (.ref_clk(ref_clk), .reset_n(reset_n),
        .ctrl_one_wr(ctrl_one_wr), .ctrl_one_wdata(ctrl_one_wdata),
        .ctrl_two_wr(ctrl_two_wr), .ctrl_two_wdata(ctrl_two_wdata),
        .result_high_rd(result_high_rd), .result_low_rd(result_low_rd),
        .stop_mode(stop_mode), .sar_value(sar_value),
        .adc_control_one(adc_control_one), .adc_control_two(adc_control_two),
        .result_high_reg(result_high_reg), .result_low_reg(result_low_reg),
        .channel_select(channel_select), .input_disable(input_disable),
        .sample_active(sample_active), .ladder_connect(ladder_connect),
        .conversion_done_irq(conversion_done_irq));
    acs_analog_model u_acs_analog_model (.channel_select(channel_select),
        .input_disable(input_disable), .sar_value(sar_value));
    // ----------
    // access tasks; every change lands 5 ns after a rising edge
    // ----------
    task automatic step();
        @(posedge ref_clk);
        #5;
    endtask : step
    task automatic chk(input string nm, input logic [10:0] seen,
        input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_one(input logic [7:0] d);
        ctrl_one_wr = 1'b1;
        ctrl_one_wdata = d;
        step();
        ctrl_one_wr = 1'b0;
    endtask : wr_one
    task automatic wr_two(input logic [7:0] d);
        ctrl_two_wr = 1'b1;
        ctrl_two_wdata = d;
        step();
        ctrl_two_wr = 1'b0;
    endtask : wr_two
    task automatic rd_high();
        result_high_rd = 1'b1;
        step();
        result_high_rd = 1'b0;
    endtask : rd_high
    // bounded wait; returns the cycles spent
    task automatic wait_irq(input int lim, output int cyc);
        cyc = 0;
        while (conversion_done_irq !== 1'b1 && cyc < lim) begin
            step();
            cyc++;
        end
    endtask : wait_irq
    // result as the whole 10-bit value
    function automatic logic [10:0] res();
        return {1'b0, result_high_reg, result_low_reg.result_lsbs};
    endfunction : res
    function automatic logic [10:0] lvl(input logic [3:0] ch);
        return {1'b0, ch, 6'h2d};
    endfunction : lvl
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // ----------
    // clock and watchdog
    // ----------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #(40 * 12000);
        n_mismatch++;
        results();
    end
    // ----------
    // tests
    // ----------
    // no port traffic driven
    initial begin
        {reset_n, ctrl_one_wr, ctrl_two_wr, stop_mode} = 4'h0;
        {result_high_rd, result_low_rd} = 2'h0;
        {ctrl_one_wdata, ctrl_two_wdata} = 16'h0000;
        n_mismatch = 0;
        n_compared = 0;
        repeat (16) @(posedge ref_clk);
        #5;
        reset_n = 1'b1;
        chk("ctrl_one", adc_control_one, 11'h000);
        chk("result", res(), 11'h000);
        // every time code, software start, controls first
        for (int i = 0; i < 6; i++) begin
            wr_two({4'h1, codes[i], 1'b0});
            wr_one({3'h5, 1'b0, 4'(i + 3)});
            step();
            chk("busy", sample_active, 11'h001);
            chk("trigger", adc_control_one[7], 11'h000);
            wait_irq(1500, n);
            chk("length", 11'(n), 11'(lens[i]));
            chk("result", res(), lvl(4'(i + 3)));
            chk("done", result_low_reg[5], 11'h001);
            rd_high();
            chk("done_rd", result_low_reg[5], 11'h000);
        end
        // restart without reading keeps the old result
        wr_one(8'ha1);
        wait_irq(60, n);
        wr_one(8'hb2);
        step();
        chk("done_new", result_low_reg[5], 11'h000);
        chk("kept", res(), lvl(4'h1));
        wait_irq(60, n);
        chk("newres", res(), 11'h2aa);
        // repeat mode chains, then the disable code aborts
        wr_one(8'he6);
        wait_irq(60, n);
        step();
        chk("chain", sample_active, 11'h001);
        wait_irq(60, n);
        chk("period", 11'(n), 11'd38);
        repeat (10) step();
        wr_one(8'h00);
        chk("abort", sample_active, 11'h000);
        wait_irq(60, n);
        chk("no_irq", 11'(n), 11'd60);
        chk("held", res(), lvl(4'h6));
        // start held off right after a zero write
        wr_one(8'h00);
        step();
        wr_one(8'ha4);
        step();
        chk("guard", sample_active, 11'h000);
        repeat (8) step();
        chk("late", sample_active, 11'h001);
        wait_irq(60, n);
        // stop mode mid-conversion, ladder always on
        wr_two(8'h30);
        wr_one(8'ha7);
        step();
        chk("ladder", ladder_connect, 11'h001);
        stop_mode = 1'b1;
        #1;
        chk("ladder_off", ladder_connect, 11'h000);
        step();
        chk("ctrl_two", adc_control_two, 11'h000);
        chk("lost", res(), 11'h000);
        chk("busy_off", sample_active, 11'h000);
        wr_one(8'ha5);
        chk("locked", adc_control_one, 11'h000);
        stop_mode = 1'b0;
        wait_irq(100, n);
        chk("no_resume", sample_active | conversion_done_irq, 11'h0);
        wr_two(8'h10);
        wr_one(8'ha8);
        wait_irq(60, n);
        chk("again", res(), lvl(4'h8));
        results();
    end
endmodule : tb_acs_sequencer
`default_nettype wire
